/* File: pkg/cpm_pkg.sv */
// package for the control pin mode logic: register map, reset values, mode codes
// assumes a 32-bit avalon-mm slave with word addressing by byte offset
package cpm_pkg;
    localparam int          CPM_NCH          = 8;
    localparam int          CPM_AW           = 4;
    localparam logic [3:0]  CPM_OFS_OUT      = 4'h0;
    localparam logic [3:0]  CPM_OFS_MAP_A    = 4'h4;
    localparam logic [3:0]  CPM_OFS_MAP_B    = 4'h8;
    localparam logic [3:0]  CPM_OFS_STATUS   = 4'hc;
    localparam logic [7:0]  CPM_RST_OUT      = 8'h00;
    localparam logic [7:0]  CPM_RST_MAP_A    = 8'h04;
    localparam logic [7:0]  CPM_RST_MAP_B    = 8'h08;
    localparam int          CPM_ST_LEVEL_LSB = 0;
    localparam int          CPM_ST_MODE_LSB  = 4;
    localparam logic [31:0] CPM_UNMAPPED     = 32'hdeadbeef;

    typedef enum logic [2:0] {
        CPM_ACTIVE = 3'b001,
        CPM_SLEEP  = 3'b010,
        CPM_LIMP   = 3'b100
    } cpm_mode_t;

    typedef struct packed {
        logic a;
        logic b;
    } cpm_inputs_t;
endpackage

/* File: rtl/cpm_control_pins.sv */
// control pin mode logic: direct inputs, input mapping, low-power pin mode select
// assumes async pins are synchronised here and the serial block obeys serial_enable_out
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
// Function
// RULE1: after reset input a drives channel 2 and input b drives channel 3 only.
// RULE2: each direct input has its own software-writable channel map register.
// RULE3: each channel drive is the or of its output bit, mapped pwm and mapped inputs.
// RULE4: input levels are readable in a status register that also updates in limp-home.
// RULE5: low-power pin low with any input high enters limp-home, default channels on.
// RULE6: low-power pin low with both inputs low enters sleep.
// RULE7: the host holds the low-power pin for the transition time before relying on it.
// RULE8: the low-power pin low returns every serial register to its default.
// RULE9: in sleep the serial interface is refused and its data output stays released.
// RULE10: in sleep the supply undervoltage detectors are disabled.
// RULE11: direct inputs and the low-power pin are synchronised before use.
module cpm_control_pins #(
    parameter int NCH = 8
) (
    input  wire logic                   clock_in,          // 25 mhz clock
    input  wire logic                   nrst_in,           // async reset, active low
    input  wire logic                   clk_en_in,         // freezes state when low
    input  wire logic                   direct_input_a_in, // direct input pin a
    input  wire logic                   direct_input_b_in, // direct input pin b
    input  wire logic                   low_power_n_in,    // low-power control pin
    input  wire logic [NCH-1:0]         pwm_mapped_in,     // mapped pwm generator drive
    input  wire logic [cpm_pkg::CPM_AW-1:0] avs_address,   // byte address
    input  wire logic                   avs_read,          // read strobe
    input  wire logic                   avs_write,         // write strobe
    input  wire logic [31:0]            avs_writedata,     // write data
    input  wire logic [3:0]             avs_byteenable,    // byte lanes
    output logic [31:0]                 avs_readdata,      // read data
    output logic                        avs_waitrequest,   // stall
    output logic [NCH-1:0]              channel_drive_out, // switch command per channel
    output cpm_pkg::cpm_mode_t          mode_out,          // current mode
    output logic                        serial_enable_out, // serial port may talk
    output logic                        uv_detect_en_out,  // undervoltage detectors on
    output logic                        serial_reset_out   // serial registers held reset
);
    import cpm_pkg::*;

    // agree filter: a level is taken only once two successive stages match
    function automatic logic cpm_agree(input logic stage2,
                                       input logic stage3,
                                       input logic held);
        logic level;
        level = held;
        if (stage2 == stage3) begin
            level = stage3;
        end
        return level;
    endfunction

    // a direct input adds its channel map to the drive while its level is high
    function automatic logic [NCH-1:0] cpm_mapped(input logic           level,
                                                  input logic [NCH-1:0] map);
        return {NCH{level}} & map;
    endfunction

    // register select against one byte offset
    function automatic logic cpm_hit(input logic [CPM_AW-1:0] addr,
                                     input logic [CPM_AW-1:0] offset);
        return addr == offset;
    endfunction

    // pin synchronisers, stage one is read only by stage two
    logic              sync_a1_q;
    logic              sync_a2_q;
    logic              sync_a3_q;
    logic              lvl_a_q;
    logic              sync_b1_q;
    logic              sync_b2_q;
    logic              sync_b3_q;
    logic              lvl_b_q;
    logic              lp_sync1_q;
    logic              lp_sync2_q;
    logic              lp_sync3_q;
    logic              lp_lvl_q;
    cpm_inputs_t       lvl;

    // serial-side registers and mode
    logic [NCH-1:0]    out_q;
    logic [NCH-1:0]    map_a_q;
    logic [NCH-1:0]    map_b_q;
    cpm_mode_t         mode_q;
    cpm_mode_t         mode_d;

    // bus handshake
    logic              ack_q;
    logic [31:0]       rdata_q;

    assign lvl = '{a: lvl_a_q, b: lvl_b_q};

    // pin a idles low, so leaving reset shows no false edge
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync_a1_q <= 1'b0;
            sync_a2_q <= 1'b0;
            sync_a3_q <= 1'b0;
            lvl_a_q   <= 1'b0;
        end else if (clk_en_in) begin
            sync_a1_q <= direct_input_a_in;                         // RULE11
            sync_a2_q <= sync_a1_q;
            sync_a3_q <= sync_a2_q;
            lvl_a_q   <= cpm_agree(sync_a2_q, sync_a3_q, lvl_a_q);
        end
    end

    // pin b idles low as well
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync_b1_q <= 1'b0;
            sync_b2_q <= 1'b0;
            sync_b3_q <= 1'b0;
            lvl_b_q   <= 1'b0;
        end else if (clk_en_in) begin
            sync_b1_q <= direct_input_b_in;                         // RULE11
            sync_b2_q <= sync_b1_q;
            sync_b3_q <= sync_b2_q;
            lvl_b_q   <= cpm_agree(sync_b2_q, sync_b3_q, lvl_b_q);
        end
    end

    // low-power pin idles high: reset must not look like a low-power request
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lp_sync1_q <= 1'b1;
            lp_sync2_q <= 1'b1;
            lp_sync3_q <= 1'b1;
            lp_lvl_q   <= 1'b1;
        end else if (clk_en_in) begin
            lp_sync1_q <= low_power_n_in;                           // RULE11
            lp_sync2_q <= lp_sync1_q;
            lp_sync3_q <= lp_sync2_q;
            lp_lvl_q   <= cpm_agree(lp_sync2_q, lp_sync3_q, lp_lvl_q);
        end
    end

    // mode decisions use only filtered levels, never raw pins
    wire any_in   = lvl.a | lvl.b;
    wire lp_low   = !lp_lvl_q;
    wire sreg_rst = lp_low;                                         // RULE8

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            CPM_ACTIVE: begin
                if (lp_low && any_in) begin
                    mode_d = CPM_LIMP;                              // RULE5
                end else if (lp_low) begin
                    mode_d = CPM_SLEEP;                             // RULE6
                end else begin
                    mode_d = CPM_ACTIVE;
                end
            end
            CPM_SLEEP: begin
                if (!lp_low) begin
                    mode_d = CPM_ACTIVE;
                end else if (any_in) begin
                    mode_d = CPM_LIMP;                              // RULE5
                end else begin
                    mode_d = CPM_SLEEP;
                end
            end
            CPM_LIMP: begin
                if (!lp_low) begin
                    mode_d = CPM_ACTIVE;
                end else if (!any_in) begin
                    mode_d = CPM_SLEEP;                             // RULE6
                end else begin
                    mode_d = CPM_LIMP;
                end
            end
            default: begin
                mode_d = CPM_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_q <= CPM_ACTIVE;
        end else if (clk_en_in) begin
            mode_q <= mode_d;
        end
    end

    wire in_active = mode_q == CPM_ACTIVE;
    wire in_sleep  = mode_q == CPM_SLEEP;

    // bus decode; a request is taken with waitrequest high and commits one
    // cycle later, at the edge where the master samples waitrequest low
    wire sel_out  = cpm_hit(avs_address, CPM_OFS_OUT);
    wire sel_ma   = cpm_hit(avs_address, CPM_OFS_MAP_A);
    wire sel_mb   = cpm_hit(avs_address, CPM_OFS_MAP_B);
    wire sel_st   = cpm_hit(avs_address, CPM_OFS_STATUS);
    wire bus_req  = avs_read | avs_write;
    wire req      = bus_req & !ack_q;
    wire commit   = bus_req & ack_q;
    wire rd_ok    = req & avs_read;
    wire wr_ok    = avs_write & commit & avs_byteenable[0]
                  & !sreg_rst & in_active;
    wire wr_out   = wr_ok & sel_out;
    wire wr_ma    = wr_ok & sel_ma;                                 // RULE2
    wire wr_mb    = wr_ok & sel_mb;                                 // RULE2

    wire [31:0] st_level = 32'(lvl) << CPM_ST_LEVEL_LSB;            // RULE4
    wire [31:0] st_mode  = 32'(mode_q) << CPM_ST_MODE_LSB;
    wire [31:0] st_word  = st_level | st_mode;
    wire [31:0] rd_mux   = sel_out ? 32'(out_q) :
                           sel_ma  ? 32'(map_a_q) :
                           sel_mb  ? 32'(map_b_q) :
                           sel_st  ? st_word : CPM_UNMAPPED;

    // output register, back to default while the low-power pin is low
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            out_q <= NCH'(CPM_RST_OUT);
        end else if (clk_en_in) begin
            if (sreg_rst) begin
                out_q <= NCH'(CPM_RST_OUT);                         // RULE8
            end else if (wr_out) begin
                out_q <= avs_writedata[NCH-1:0];
            end
        end
    end

    // map of input a, default channel 2
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            map_a_q <= NCH'(CPM_RST_MAP_A);                         // RULE1
        end else if (clk_en_in) begin
            if (sreg_rst) begin
                map_a_q <= NCH'(CPM_RST_MAP_A);                     // RULE8
            end else if (wr_ma) begin
                map_a_q <= avs_writedata[NCH-1:0];
            end
        end
    end

    // map of input b, default channel 3
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            map_b_q <= NCH'(CPM_RST_MAP_B);                         // RULE1
        end else if (clk_en_in) begin
            if (sreg_rst) begin
                map_b_q <= NCH'(CPM_RST_MAP_B);                     // RULE8
            end else if (wr_mb) begin
                map_b_q <= avs_writedata[NCH-1:0];
            end
        end
    end

    // one wait cycle per access; ack drops once the commit edge is passed
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ack_q <= 1'b0;
        end else if (clk_en_in) begin
            ack_q <= req;
        end
    end

    // read data are captured when taken and stand at the commit edge
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_q <= '0;
        end else if (clk_en_in && rd_ok) begin
            rdata_q <= rd_mux;
        end
    end

    // in limp-home the maps are held at default, so inputs give default channels
    wire [NCH-1:0] pin_a_drive = cpm_mapped(lvl.a, map_a_q);        // RULE5
    wire [NCH-1:0] pin_b_drive = cpm_mapped(lvl.b, map_b_q);
    wire [NCH-1:0] reg_drive   = out_q | pwm_mapped_in;

    assign avs_waitrequest   = req;
    assign avs_readdata      = rdata_q;
    assign channel_drive_out = reg_drive | pin_a_drive | pin_b_drive; // RULE3
    assign mode_out          = mode_q;
    assign serial_enable_out = !in_sleep;                           // RULE9
    assign uv_detect_en_out  = !in_sleep;                           // RULE10
    assign serial_reset_out  = sreg_rst;
endmodule

/* File: dv/cpm_host_model.sv */
// host model: drives the direct input pins and the low-power pin
// assumes the bench holds each level for the mode transition time
`timescale 1ns/1ns
module cpm_host_model (
    input  wire logic       clock_in,                  // clock
    input  wire logic [2:0] cmd_in,                    // low-power, a, b
    output logic            low_power_n_out    = 1'b1, // low-power pin
    output logic            direct_input_a_out = 1'b0, // pin a
    output logic            direct_input_b_out = 1'b0  // pin b
);
    always @(posedge clock_in) begin
        {low_power_n_out, direct_input_a_out, direct_input_b_out} <= cmd_in;
    end
endmodule

/* File: dv/cpm_chk_chk.sv */
// checker on the ports of the control pin logic
// assumes clk_en_in stays high
`timescale 1ns/1ns
module cpm_chk #(parameter int NCH = 8) (
    input wire logic               clock_in,          // clock
    input wire logic               nrst_in,           // reset
    input wire logic               direct_input_a_in, // pin a
    input wire logic               direct_input_b_in, // pin b
    input wire logic               low_power_n_in,    // low-power pin
    input wire logic [NCH-1:0]     pwm_mapped_in,     // pwm drive
    input wire logic               avs_read,          // read
    input wire logic               avs_write,         // write
    input wire logic               avs_waitrequest,   // stall
    input wire logic [NCH-1:0]     channel_drive_out, // drive
    input wire cpm_pkg::cpm_mode_t mode_out,          // mode
    input wire logic               serial_enable_out, // serial on
    input wire logic               uv_detect_en_out,  // uv on
    input wire logic               serial_reset_out   // serial reset
);
    import cpm_pkg::*;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    sequence s_sleep;
        (!low_power_n_in && !direct_input_a_in && !direct_input_b_in)[*8];
    endsequence
    sequence s_limp;
        (!low_power_n_in && direct_input_a_in && !direct_input_b_in)[*8];
    endsequence
    AST_SLEEP_MODE: assert property (s_sleep |-> mode_out == CPM_SLEEP)
        else $error("sleep not entered");
    AST_SLEEP_SER: assert property (s_sleep |-> !serial_enable_out)
        else $error("serial on in sleep");
    AST_SLEEP_UV: assert property (s_sleep |-> !uv_detect_en_out)
        else $error("uv on in sleep");
    AST_LIMP_MODE: assert property (s_limp |-> mode_out == CPM_LIMP)
        else $error("limp not entered");
    AST_LIMP_DRV: assert property (s_limp |-> channel_drive_out[2])
        else $error("limp channel off");
    AST_LP_RST: assert property ((!low_power_n_in)[*8] |-> serial_reset_out)
        else $error("serial regs not reset");
    AST_PWM_OR: assert property ((channel_drive_out & pwm_mapped_in) == pwm_mapped_in)
        else $error("pwm not in drive");
    AST_ACK: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer late");
endmodule
bind cpm_control_pins cpm_chk #(.NCH(NCH)) u_chk (.clock_in, .nrst_in, .direct_input_a_in,
    .direct_input_b_in, .low_power_n_in, .pwm_mapped_in, .avs_read, .avs_write,
    .avs_waitrequest, .channel_drive_out, .mode_out, .serial_enable_out, .uv_detect_en_out,
    .serial_reset_out);

/* File: dv/testbench.sv */
// bench: avalon access and pin levels against expected drive, status and mode
// assumes one wait cycle per access as the design answers
`timescale 1ns/1ns
module testbench;
    import cpm_pkg::*;
    logic clk = 0, nrst = 0, rd = 0, wr = 0, pa, pb, plp, wt, sen, uv, srs;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, rdw, rdat;
    logic [7:0] pwm = 8'h00, drv;
    logic [2:0] pins = 3'b100;
    cpm_mode_t md;
    int errors = 0, n_checks = 0;
    initial forever #20 clk = ~clk;
    cpm_host_model u_host (.clock_in(clk), .cmd_in(pins), .low_power_n_out(plp),
        .direct_input_a_out(pa), .direct_input_b_out(pb));
    cpm_control_pins u_dut (.clock_in(clk), .nrst_in(nrst), .clk_en_in(1'b1),
        .direct_input_a_in(pa), .direct_input_b_in(pb), .low_power_n_in(plp),
        .pwm_mapped_in(pwm), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdw), .avs_waitrequest(wt),
        .channel_drive_out(drv), .mode_out(md), .serial_enable_out(sen),
        .uv_detect_en_out(uv), .serial_reset_out(srs));
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (wt !== 1'b0 && i < 20);
        rdat = rdw;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
        if (i >= 20) begin
            errors++;
            $display("[FAIL] %0t bus timeout", $time);
            finish_test();
        end
    endtask
    task automatic setp(input logic [2:0] v);
        pins <= v;
        repeat (10) @(posedge clk);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        bus(0, CPM_OFS_OUT, 0);
        chk(rdat, 32'h0);
        bus(0, CPM_OFS_MAP_A, 0);
        chk(rdat, 32'h4);
        bus(0, CPM_OFS_MAP_B, 0);
        chk(rdat, 32'h8);
        bus(0, 4'h2, 0);
        chk(rdat, CPM_UNMAPPED);
        setp(3'b110);
        chk(drv, 32'h04);
        setp(3'b101);
        chk(drv, 32'h08);
        bus(1, CPM_OFS_MAP_A, 32'h81);
        bus(1, CPM_OFS_OUT, 32'h10);
        pwm <= 8'h40;
        setp(3'b110);
        chk(drv, 32'hd1);
        bus(0, CPM_OFS_STATUS, 0);
        chk(rdat, 32'h12);
        setp(3'b010);
        chk(drv, 32'h44);
        chk({md, srs, sen, uv}, {CPM_LIMP, 3'b111});
        bus(0, CPM_OFS_STATUS, 0);
        chk(rdat, 32'h42);
        bus(1, CPM_OFS_MAP_A, 32'hff);
        setp(3'b000);
        chk({md, sen, uv}, {CPM_SLEEP, 2'b00});
        setp(3'b100);
        chk({md, srs, sen, uv}, {CPM_ACTIVE, 3'b011});
        bus(0, CPM_OFS_MAP_A, 0);
        chk(rdat, 32'h4);
        finish_test();
    end
endmodule
